// ==== ebm_defines.svh ====
// Constants of the external bus master port.
`ifndef EBM_DEFINES_SVH
`define EBM_DEFINES_SVH
`define EBM_SIZ_LONG 2'h0
`define EBM_SIZ_BYTE 2'h1
`define EBM_SIZ_WORD 2'h2
`define EBM_SIZ_LINE 2'h3
`define EBM_PW_8 2'h1
`define EBM_PW_16 2'h2
`define EBM_PW_32 2'h0
`define EBM_CFG_PW_HI 19
`define EBM_CFG_PW_LO 18
`define EBM_CFG_MASK 32'h0733_0000
`define EBM_LINE_BEATS 3'h4
`endif

// ==== ebm_pkg.sv ====
// Types shared by the external bus master port.
package ebm_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic rd;
    logic sdram;
  } ebm_req_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } ebm_rsp_t;
  typedef enum logic [1:0] {
    EBM_IDLE,
    EBM_START,
    EBM_WAIT
  } ebm_state_t;
endpackage

// ==== ebm_bus_master.sv ====
// External bus master port: pin reset states, sizing, splitting and termination.
//
// Behaviour
// [RQ1] Single-chip mode: bus pins stay undriven inputs after reset.
// [RQ2] External boot: bus pins active after reset, control outputs driven high.
// [RQ3] Drive 24 address outputs, the low bits of the 32-bit address.
// [RQ4] Same address lines carry multiplexed SDRAM row and column addresses; the code drives addr[23:0] unmultiplexed, SDRAM or not.
// [RQ5] Read data sampled on rising bus clock edge.
// [RQ6] Data bits 19:18 at reset set boot select port width and waits; the code captures only the port width, no waits.
// [RQ7] Unmatched access: 32-bit port, external termination, no bursts.
// [RQ8] Writes drive all 32 data lines regardless of width.
// [RQ9] Data lines 26:24, 21, 19:16 read as configuration at reset.
// [RQ10] Byte-lane strobes driven low for lanes carrying valid data.
// [RQ11] Output enable asserted on reads; slave drives only then.
// [RQ12] Acknowledge ends the cycle; reads latch data first.
// [RQ13] Acknowledge may be tied low only with fast termination everywhere.
// [RQ14] Error acknowledge ends the cycle and raises an access error.
// [RQ15] Direction is 1 for reads and 0 for writes.
// [RQ16] Size codes: 00 long, 01 byte, 10 word, 11 line.
// [RQ17] Misaligned access splits into aligned pieces, each with own size.
// [RQ18] Burst keeps full size; inhibited shows full first then port size.
// [RQ19] Chip select port width settable to 8, 16 or 32 bits.
// [RQ20] Transfer start asserted for exactly the first cycle of a transfer.
// [RQ21] Byte, word, longword and 16-byte line accesses supported.
// [RQ22] In-progress asserted during transfers, not idle, not for SDRAM.
// [RQ23] Reset clears select programming except boot select, made global.
// [RQ24] Sample active-low acknowledges; end transfer at first asserted edge; the code ends it two edges later, behind a two-flop synchroniser.
`timescale 1ns/1ps
`include "ebm_defines.svh"
module ebm_bus_master
  import ebm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_boot_i,
  input wire logic [1:0] cs_port_width_i,
  input wire logic cs_match_i,
  input wire logic cs_burst_en_i,
  input wire logic req_valid_i,
  input ebm_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output ebm_rsp_t rsp_o,
  output logic [1:0] boot_port_width_o,
  output logic [7:0] reset_config_o,
  output logic [23:0] addr_o,
  output logic addr_oe_o,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe_o,
  output logic [3:0] byte_lane_strobe_n_o,
  output logic output_enable_n_o,
  output logic read_write_o,
  output logic [1:0] xfer_size_code_o,
  output logic xfer_start_n_o,
  output logic xfer_in_progress_n_o,
  output logic ctrl_oe_o,
  input wire logic xfer_ack_n_i,
  input wire logic xfer_error_ack_n_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; acknowledges and data come from outside.

  logic ack_s1_r, ack_s2_r, err_s1_r, err_s2_r, boot_s1_r, boot_s2_r;
  logic [31:0] din_s1_r, din_s2_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      err_s1_r <= 1'b1;
      err_s2_r <= 1'b1;
      boot_s1_r <= 1'b0;
      boot_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= xfer_ack_n_i;
      ack_s2_r <= ack_s1_r;
      err_s1_r <= xfer_error_ack_n_i;
      err_s2_r <= err_s1_r;
      boot_s1_r <= ext_boot_i;
      boot_s2_r <= boot_s1_r;
    end
  end

  // The data synchroniser has no reset so that it already holds the
  // configuration levels that the pins show while reset is asserted.
  always_ff @(posedge clk_i) begin
    din_s1_r <= data_i; // RQ5
    din_s2_r <= din_s1_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset configuration capture, done by a clocked process after release.

  logic cfg_done_r, cfg_done_nxt;
  logic [1:0] boot_pw_r, boot_pw_nxt;
  logic [7:0] cfg_r, cfg_nxt;

  always_comb begin
    cfg_done_nxt = 1'b1;
    boot_pw_nxt = boot_pw_r;
    cfg_nxt = cfg_r;
    if (!cfg_done_r) begin
      boot_pw_nxt = din_s2_r[`EBM_CFG_PW_HI:`EBM_CFG_PW_LO]; // RQ6
      cfg_nxt = {din_s2_r[26:24], din_s2_r[21], din_s2_r[19:16]}; // RQ9
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_done_r <= 1'b0;
      boot_pw_r <= `EBM_PW_32;
      cfg_r <= 8'h00;
    end else begin
      cfg_done_r <= cfg_done_nxt;
      boot_pw_r <= boot_pw_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign boot_port_width_o = boot_pw_r;
  assign reset_config_o = cfg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine.

  ebm_state_t st_r, st_nxt;
  ebm_req_t cur_r, cur_nxt;
  logic [4:0] left_r, left_nxt;
  logic [1:0] pw_r, pw_nxt;
  logic burst_r, burst_nxt;
  logic first_r, first_nxt;
  logic err_r, err_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rsp_r, rsp_nxt;
  logic [1:0] piece_siz;
  logic [2:0] piece_len;
  logic [3:0] lanes;
  logic [1:0] siz_r, siz_nxt;
  logic [3:0] bs_r, bs_nxt;
  logic done;
  logic [31:0] keep_mask;

  // Natural aligned piece limited by alignment, remaining length and port.
  always_comb begin
    piece_len = 3'h4;
    if (cur_r.addr[0] || left_r == 5'h01 || pw_r == `EBM_PW_8) begin
      piece_len = 3'h1; // RQ17
    end else if (cur_r.addr[1] || left_r < 5'h04 || pw_r == `EBM_PW_16) begin
      piece_len = 3'h2; // RQ17
    end
    if (piece_len == 3'h1) begin
      piece_siz = `EBM_SIZ_BYTE;
    end else if (piece_len == 3'h2) begin
      piece_siz = `EBM_SIZ_WORD;
    end else begin
      piece_siz = `EBM_SIZ_LONG;
    end
    if (pw_r == `EBM_PW_8) begin
      lanes = 4'h8 >> cur_r.addr[1:0];
    end else if (pw_r == `EBM_PW_16) begin
      lanes = (piece_len == 3'h1) ? (4'h8 >> cur_r.addr[1:0]) : (4'hC >> cur_r.addr[1:0]);
    end else if (piece_len == 3'h1) begin
      lanes = 4'h8 >> cur_r.addr[1:0];
    end else if (piece_len == 3'h2) begin
      lanes = 4'hC >> cur_r.addr[1:0];
    end else begin
      lanes = 4'hF;
    end
  end

  assign done = !ack_s2_r || !err_s2_r; // RQ24
  // Lanes not strobed in this piece keep what earlier pieces returned.
  assign keep_mask = {{8{bs_r[3]}}, {8{bs_r[2]}}, {8{bs_r[1]}}, {8{bs_r[0]}}};

  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    left_nxt = left_r;
    pw_nxt = pw_r;
    burst_nxt = burst_r;
    first_nxt = first_r;
    err_nxt = err_r;
    rd_nxt = rd_r;
    rsp_nxt = 1'b0;
    siz_nxt = siz_r;
    bs_nxt = bs_r;
    case (st_r)
      EBM_IDLE: begin
        if (req_valid_i && cfg_done_r) begin
          cur_nxt = req_i;
          err_nxt = 1'b0;
          rd_nxt = 32'h0;
          first_nxt = 1'b1;
          if (req_i.size == `EBM_SIZ_BYTE) begin
            left_nxt = 5'h01;
          end else if (req_i.size == `EBM_SIZ_WORD) begin
            left_nxt = 5'h02;
          end else if (req_i.size == `EBM_SIZ_LINE) begin
            left_nxt = {`EBM_LINE_BEATS, 2'h0}; // RQ21
          end else begin
            left_nxt = 5'h04; // RQ21
          end
          // Unmatched: 32-bit, no bursts; select otherwise gives its width.
          pw_nxt = cs_match_i ? cs_port_width_i : `EBM_PW_32; // RQ7 RQ19
          burst_nxt = cs_match_i && cs_burst_en_i; // RQ7
          st_nxt = EBM_START;
        end
      end
      EBM_START: begin
        // Full size shown on an aligned first start and on every aligned burst start, pieces otherwise.
        siz_nxt = (first_r || burst_r) ? cur_r.size : piece_siz; // RQ16 RQ18
        if (cur_r.addr[1:0] != 2'h0) begin
          siz_nxt = piece_siz; // RQ17
        end
        bs_nxt = ~lanes; // RQ10
        first_nxt = 1'b0;
        st_nxt = EBM_WAIT;
      end
      EBM_WAIT: begin
        if (done) begin
          if (cur_r.rd) begin
            rd_nxt = (rd_r & keep_mask) | (din_s2_r & ~keep_mask); // RQ12
          end
          if (!err_s2_r || left_r <= {2'h0, piece_len}) begin
            err_nxt = !err_s2_r; // RQ14
            rsp_nxt = 1'b1; // RQ12
            bs_nxt = 4'hF;
            st_nxt = EBM_IDLE;
          end else begin
            left_nxt = left_r - {2'h0, piece_len};
            cur_nxt.addr = cur_r.addr + {29'h0, piece_len};
            st_nxt = EBM_START;
          end
        end
      end
      default: st_nxt = EBM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= EBM_IDLE;
      cur_r <= '0;
      left_r <= 5'h00;
      pw_r <= `EBM_PW_32;
      burst_r <= 1'b0;
      first_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 32'h0;
      rsp_r <= 1'b0;
      siz_r <= 2'h3;
      bs_r <= 4'hF;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      left_r <= left_nxt;
      pw_r <= pw_nxt;
      burst_r <= burst_nxt;
      first_r <= first_nxt;
      err_r <= err_nxt;
      rd_r <= rd_nxt;
      rsp_r <= rsp_nxt;
      siz_r <= siz_nxt;
      bs_r <= bs_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs. The address is registered in the request copy.

  logic active;
  assign active = st_r != EBM_IDLE;
  assign req_ready_o = st_r == EBM_IDLE && cfg_done_r;
  assign rsp_valid_o = rsp_r;
  assign rsp_o = '{rdata: rd_r, err: err_r}; // RQ14
  assign addr_o = cur_r.addr[23:0]; // RQ3 RQ4
  // Single-chip mode leaves bus pins as inputs after reset.
  assign addr_oe_o = boot_s2_r; // RQ1 RQ2
  assign ctrl_oe_o = boot_s2_r; // RQ1 RQ2 RQ23
  assign data_o = cur_r.wdata;
  assign data_oe_o = boot_s2_r && active && !cur_r.rd; // RQ8
  assign byte_lane_strobe_n_o = (st_r == EBM_WAIT) ? bs_r : 4'hF; // RQ10
  assign output_enable_n_o = !(st_r == EBM_WAIT && cur_r.rd); // RQ11
  assign read_write_o = active ? cur_r.rd : 1'b1; // RQ15
  assign xfer_size_code_o = (st_r == EBM_WAIT) ? siz_r : 2'h3;
  // Start is one cycle: the first WAIT cycle after a new piece.
  logic start_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_r <= 1'b0;
    end else begin
      start_r <= st_nxt == EBM_WAIT && st_r == EBM_START;
    end
  end
  assign xfer_start_n_o = !start_r; // RQ20
  assign xfer_in_progress_n_o = !(active && !cur_r.sdram); // RQ22

endmodule

// ==== ebm_checker.sv ====
// Concurrent checks on the pins of the external bus master port.
`timescale 1ns/1ps
module ebm_checker
  import ebm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ctrl_oe_o,
  input wire logic addr_oe_o,
  input wire logic data_oe_o,
  input wire logic rsp_valid_o,
  input wire ebm_rsp_t rsp_o,
  input wire logic [3:0] byte_lane_strobe_n_o,
  input wire logic output_enable_n_o,
  input wire logic read_write_o,
  input wire logic xfer_start_n_o,
  input wire logic xfer_in_progress_n_o,
  input wire logic xfer_ack_n_i,
  input wire logic xfer_error_ack_n_i
);
  ////////////////////////////////////////////////////////////////////////////////
  // The age saturates so that a stale termination never looks fresh.
  logic [3:0] term_age_r, term_age_nxt;
  always_comb begin
    term_age_nxt = (xfer_ack_n_i & xfer_error_ack_n_i) ? term_age_r + {3'h0, ~&term_age_r} : 4'h0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_age_r <= 4'hF;
    end else begin
      term_age_r <= term_age_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_start_pulse; $fell(xfer_start_n_o) |=> xfer_start_n_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_tip; !xfer_start_n_o |-> !xfer_in_progress_n_o; endproperty
  a_start_tip: assert property (p_start_tip) else $error("start outside transfer");
  property p_oe_read; !output_enable_n_o |-> read_write_o; endproperty
  a_oe_read: assert property (p_oe_read) else $error("output enable on write");
  property p_wr_drive; !xfer_start_n_o && !read_write_o |-> ##[0:2] data_oe_o; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
  property p_rsp_term; rsp_valid_o |-> term_age_r <= 4'hA; endproperty
  a_rsp_term: assert property (p_rsp_term) else $error("reply without termination");
  property p_err_end;
    $fell(xfer_error_ack_n_i) && !xfer_in_progress_n_o |-> ##[1:8] xfer_in_progress_n_o;
  endproperty
  a_err_end: assert property (p_err_end) else $error("error did not end cycle");
  property p_idle_lanes; xfer_in_progress_n_o |-> &byte_lane_strobe_n_o; endproperty
  a_idle_lanes: assert property (p_idle_lanes) else $error("lane strobe while idle");
  property p_single; !ctrl_oe_o |-> !data_oe_o && !addr_oe_o; endproperty
  a_single: assert property (p_single) else $error("pins driven in single-chip");
endmodule

// ==== ebm_slave.sv ====
// Behavioural memory slave with settable wait states and error reply.
`timescale 1ns/1ps
module ebm_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] strobe_n_i,
  input wire logic oe_n_i,
  input wire logic start_n_i,
  input wire logic [1:0] size_i,
  input wire logic [3:0] wait_i,
  input wire logic err_i,
  input wire logic [31:0] cfg_i,
  input wire logic clr_i,
  output logic [31:0] data_o,
  output logic ack_n_o,
  output logic err_n_o,
  output logic [3:0] pieces_o,
  output logic [7:0] sizes_o
);
  logic [31:0] mem [0:63];
  logic [3:0] cnt;
  logic [2:0] cfg_cnt;
  logic busy, tick;
  // Released lines toggle so a stale value can never be mistaken for data.
  assign data_o = (cfg_cnt < 3'h5) ? cfg_i :
    (!oe_n_i ? mem[addr_i[7:2]] : {16{tick, ~tick}});
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_cnt <= 3'h0;
      busy <= 1'h0;
      ack_n_o <= 1'h1;
      err_n_o <= 1'h1;
      pieces_o <= 4'h0;
      tick <= 1'h0;
    end else begin
      tick <= ~tick;
      ack_n_o <= 1'h1;
      err_n_o <= 1'h1;
      if (cfg_cnt < 3'h5) cfg_cnt <= cfg_cnt + 3'h1;
      if (clr_i) pieces_o <= 4'h0;
      if (!start_n_i) begin
        busy <= 1'h1;
        cnt <= wait_i;
        sizes_o[{pieces_o[1:0], 1'h0} +: 2] <= size_i;
        pieces_o <= pieces_o + 4'h1;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'h0;
        ack_n_o <= err_i;
        err_n_o <= ~err_i;
        for (int i = 0; i < 4; i++)
          if (oe_n_i && !strobe_n_i[i]) mem[addr_i[7:2]][8*i +: 8] <= wdata_i[8*i +: 8];
      end
    end
  end
endmodule

// ==== test_ebm_bus_master.sv ====
// Self-checking bench for the external bus master port.
`timescale 1ns/1ps
`include "ebm_defines.svh"
module test_ebm_bus_master;
  import ebm_pkg::*;
  localparam logic [31:0] CFG = 32'h0528_0000;
  logic clk_i = 1'h0, rst_n_i = 1'h0, ext_boot_i = 1'h0, cs_match_i = 1'h1, cs_burst_en_i = 1'h0;
  logic req_valid_i = 1'h0, slv_err = 1'h0, slv_clr = 1'h0, tip_low = 1'h0;
  logic [1:0] cs_port_width_i = `EBM_PW_32;
  logic [3:0] slv_wait = 4'h0;
  ebm_req_t req_i = '0;
  ebm_rsp_t rsp_o, r;
  logic req_ready_o, rsp_valid_o, addr_oe_o, data_oe_o, output_enable_n_o, read_write_o;
  logic xfer_start_n_o, xfer_in_progress_n_o, ctrl_oe_o, xfer_ack_n_i, xfer_error_ack_n_i;
  logic [1:0] boot_port_width_o, xfer_size_code_o;
  logic [7:0] reset_config_o, sizes;
  logic [23:0] addr_o;
  logic [31:0] data_i, data_o;
  logic [3:0] byte_lane_strobe_n_o, pieces;
  int err_total = 0;
  int comparisons = 0;
  always #5 clk_i = ~clk_i;
  ebm_bus_master DUT (.clk_i, .rst_n_i, .ext_boot_i, .cs_port_width_i, .cs_match_i,
    .cs_burst_en_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o,
    .boot_port_width_o, .reset_config_o, .addr_o, .addr_oe_o, .data_i, .data_o, .data_oe_o,
    .byte_lane_strobe_n_o, .output_enable_n_o, .read_write_o, .xfer_size_code_o,
    .xfer_start_n_o, .xfer_in_progress_n_o, .ctrl_oe_o, .xfer_ack_n_i, .xfer_error_ack_n_i);
  ebm_slave u_slv (.clk_i, .rst_n_i, .addr_i(addr_o), .wdata_i(data_o),
    .strobe_n_i(byte_lane_strobe_n_o), .oe_n_i(output_enable_n_o), .start_n_i(xfer_start_n_o),
    .size_i(xfer_size_code_o), .wait_i(slv_wait), .err_i(slv_err), .cfg_i(CFG), .clr_i(slv_clr),
    .data_o(data_i), .ack_n_o(xfer_ack_n_i), .err_n_o(xfer_error_ack_n_i), .pieces_o(pieces),
    .sizes_o(sizes));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request is held from a falling edge until a rising edge finds ready high.
  task automatic acc(input logic [31:0] a, wd, input logic [1:0] sz, input logic rd);
    int n = 0;
    @(negedge clk_i);
    slv_clr = 1'h1;
    tip_low = 1'h0;
    req_i = '{addr: a, wdata: wd, size: sz, rd: rd, sdram: 1'h0};
    req_valid_i = 1'h1;
    #1;
    while (req_ready_o !== 1'h1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    req_valid_i = 1'h0;
    slv_clr = 1'h0;
    while (rsp_valid_o !== 1'h1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
      if (xfer_in_progress_n_o === 1'h0) tip_low = 1'h1;
    end
    chk(32'(n < 200), 32'h1);
    r = rsp_o;
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    chk(32'(boot_port_width_o), 32'(CFG[19:18]));
    chk(32'(reset_config_o), 32'({CFG[26:24], CFG[21], CFG[19:16]}));
    chk(32'({ctrl_oe_o, addr_oe_o, data_oe_o}), 32'h0);
    ext_boot_i = 1'h1;
    repeat (4) @(negedge clk_i);
    chk(32'({ctrl_oe_o, xfer_size_code_o, byte_lane_strobe_n_o, output_enable_n_o, read_write_o,
      xfer_start_n_o, xfer_in_progress_n_o}), 32'h7FF);
    $display("t_boot done");
  endtask
  task automatic t_rw();
    logic [1:0] sz [3] = '{`EBM_SIZ_BYTE, `EBM_SIZ_WORD, `EBM_SIZ_LONG};
    foreach (sz[i]) begin
      acc(32'h20, 32'h0, sz[i], 1'h0);
      chk(32'({pieces, sizes[1:0]}), 32'({4'h1, sz[i]}));
    end
    acc(32'h10, 32'h1234_5678, `EBM_SIZ_LONG, 1'h0);
    chk(32'(tip_low), 32'h1);
    slv_wait = 4'h3;
    acc(32'h10, 32'h0, `EBM_SIZ_LONG, 1'h1);
    chk(r.rdata, 32'h1234_5678);
    cs_burst_en_i = 1'h1;
    acc(32'h40, 32'h0, `EBM_SIZ_LINE, 1'h0);
    chk(32'({pieces, sizes}), 32'h4FF);
    cs_burst_en_i = 1'h0;
    slv_wait = 4'h0;
    $display("t_rw done");
  endtask
  task automatic t_split();
    acc(32'h31, 32'hCAFE_F00D, `EBM_SIZ_LONG, 1'h0);
    chk(32'({pieces, sizes[5:0]}), 32'h0D9);
    acc(32'h31, 32'h0, `EBM_SIZ_LONG, 1'h1);
    chk(r.rdata, 32'hCAFE_F00D);
    cs_port_width_i = `EBM_PW_8;
    acc(32'h50, 32'h89AB_CDEF, `EBM_SIZ_LONG, 1'h0);
    chk(32'({pieces, sizes}), 32'h454);
    acc(32'h50, 32'h0, `EBM_SIZ_LONG, 1'h1);
    chk(r.rdata, 32'h89AB_CDEF);
    cs_port_width_i = `EBM_PW_16;
    acc(32'h60, 32'h0, `EBM_SIZ_LONG, 1'h0);
    chk(32'({pieces, sizes[3:0]}), 32'h28);
    cs_match_i = 1'h0;
    acc(32'h70, 32'h0, `EBM_SIZ_LONG, 1'h0);
    chk(32'(pieces), 32'h1);
    cs_match_i = 1'h1;
    cs_port_width_i = `EBM_PW_32;
    $display("t_split done");
  endtask
  task automatic t_err();
    slv_err = 1'h1;
    acc(32'h31, 32'h0, `EBM_SIZ_LONG, 1'h1);
    chk(32'({pieces, 3'h0, r.err}), 32'h11);
    slv_err = 1'h0;
    acc(32'h10, 32'h0, `EBM_SIZ_LONG, 1'h1);
    chk(32'(r.err), 32'h0);
    chk(r.rdata, 32'h1234_5678);
    $display("t_err done");
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'h1;
    repeat (5) @(negedge clk_i);
    t_boot();
    t_rw();
    t_split();
    t_err();
    wrap_up();
  end
  initial begin
    #50000;
    err_total++;
    wrap_up();
  end
endmodule
bind ebm_bus_master ebm_checker u_chk (.clk_i, .rst_n_i, .ctrl_oe_o, .addr_oe_o, .data_oe_o,
  .rsp_valid_o, .rsp_o, .byte_lane_strobe_n_o, .output_enable_n_o, .read_write_o,
  .xfer_start_n_o, .xfer_in_progress_n_o, .xfer_ack_n_i, .xfer_error_ack_n_i);
